// >>> core/nvc_pkg.sv
// Constants shared by the nested vector controller and its source select
package nvc_pkg;
   localparam int NUM_SYS = 16;
   localparam int NUM_IRQ = 32;
   localparam int NUM_EXC = 48;
   localparam int DMA_GRP_W = 16;
   localparam logic [5:0] EXC_RESET = 6'h01;
   localparam logic [5:0] EXC_NMI = 6'h02;
   localparam logic [5:0] EXC_HARD = 6'h03;
   localparam logic [5:0] EXC_MEM = 6'h04;
   localparam logic [5:0] EXC_BUS = 6'h05;
   localparam logic [5:0] EXC_USAGE = 6'h06;
   localparam logic [5:0] EXC_CALL = 6'h0b;
   localparam logic [5:0] EXC_DBG = 6'h0c;
   localparam logic [5:0] EXC_DEFER = 6'h0e;
   localparam logic [5:0] EXC_TICK = 6'h0f;
   localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
   localparam logic [9:0] OFF_SP = 10'h000;
   localparam logic [9:0] OFF_RESET = 10'h004;
   localparam logic [47:0] PROG_MASK = 48'hffff_ffff_d870;
   localparam logic [47:0] RSVD_MASK = 48'h0000_0000_2781;
   localparam logic [31:0] FIXED_RSVD = 32'h0400_0004;
   localparam logic [1:0] SRC_FIXED = 2'h0;
   localparam logic [1:0] SRC_DMA = 2'h1;
   localparam logic [1:0] SRC_ROUTE = 2'h2;
   localparam logic [4:0] KEY_RESET = 5'h00;
   localparam logic [4:0] KEY_NMI = 5'h01;
   localparam logic [4:0] KEY_HARD = 5'h02;
   localparam logic [4:0] KEY_PROG = 5'h03;
   localparam logic [4:0] KEY_THREAD = 5'h1f;
   typedef enum logic [4:0] {
      ST_BOOT_SP = 5'b00001,
      ST_BOOT_PC = 5'b00010,
      ST_RUN = 5'b00100,
      ST_STACK = 5'b01000,
      ST_UNSTACK = 5'b10000
   } ctl_state_e;
endpackage : nvc_pkg

// >>> core/irq_source_select.sv
// Per-vector choice of interrupt source: fixed line, DMA or routing array
`timescale 1ns/1ps
`default_nettype none
module irq_source_select #(
   parameter int N = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic src_we,
   input wire logic [4:0] src_idx,
   input wire logic [1:0] src_val,
   input wire logic [N-1:0] fixed_irq,
   input wire logic [15:0] dma_term_group_zero,
   input wire logic [15:0] dma_term_group_one,
   input wire logic [N-1:0] route_irq,
   output logic [N-1:0] irq_out
);
   generate
      if (N != nvc_pkg::NUM_IRQ) begin : g_bad_n
         $error("irq_source_select serves exactly 32 vectors");
      end
   endgenerate

   logic [N-1:0][1:0] sel_r;
   logic [N-1:0][1:0] sel_nxt;
   logic [31:0] dma_all;

   assign dma_all = {dma_term_group_one, dma_term_group_zero}; // RULE_17

   ////////////////////////////////////////////////////////////////////////
   genvar v;
   generate
      for (v = 0; v < N; v++) begin : g_vec
         always_comb begin
            sel_nxt[v] = sel_r[v];
            if (src_we && (src_idx == 5'(v))) begin
               sel_nxt[v] = src_val;
            end
         end

         always_ff @(posedge clk) begin
            if (!rst_b) begin
               sel_r[v] <= nvc_pkg::SRC_FIXED; // RULE_21
            end else if (ce) begin
               sel_r[v] <= sel_nxt[v];
            end
         end

         // Code 3 picks nothing; reserved fixed slots read as quiet
         always_comb begin
            case (sel_r[v]) // RULE_16
               nvc_pkg::SRC_FIXED: irq_out[v] =
                  fixed_irq[v] & ~nvc_pkg::FIXED_RSVD[v]; // RULE_19
               nvc_pkg::SRC_DMA: irq_out[v] = dma_all[v]; // RULE_20
               nvc_pkg::SRC_ROUTE: irq_out[v] = route_irq[v]; // RULE_18
               default: irq_out[v] = 1'b0;
            endcase
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   property p_src_reset;
      @(posedge clk) disable iff (!rst_b)
         $rose(rst_b) |-> (sel_r == '0);
   endproperty
   a_src_reset: assert property (p_src_reset) // RULE_21
      else $error("source select not fixed-function after reset");
endmodule : irq_source_select
`default_nettype wire

// >>> core/nested_vector_controller.sv
// Nested vectored interrupt controller with boot fetch and entry sequencing
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01: Sixteen system exceptions and 32 peripheral inputs share one numbering.
// RULE_02: After reset fetch stack pointer from offset 0, reset vector from 4.
// RULE_03: Reset, NMI, hard fault fixed above all; blocked faults escalate to hard fault.
// RULE_04: Memory-management fault is exception 4, programmable, vector offset 0x10.
// RULE_05: Bus error response raises exception 5, programmable, offset 0x14.
// RULE_06: Invalid instruction or state change raises exception 6, offset 0x18.
// RULE_07: 7-10 and 13 reserved; 11,12,14,15 are programmable system exceptions.
// RULE_08: Peripheral requests 0-31 become exceptions 16-47, offsets four bytes apart.
// RULE_09: Software stores every vector with bit 0 set.
// RULE_10: NMI comes from any selected pin, or from none.
// RULE_11: Eight priority levels per interrupt, changeable at run time.
// RULE_12: Priority splits into group and subpart; only higher group preempts.
// RULE_13: Tail-chain pending work after return; late arrival takes vector while stacking.
// RULE_14: Hardware pushes state on entry and pops it on exit.
// RULE_15: Equal priority goes to lower exception number first.
// RULE_16: Each vector selects fixed, DMA or routing-array source.
// RULE_17: DMA source set carries both termination outputs of every channel.
// RULE_18: Any routing-array signal may request any vector.
// RULE_19: Fixed-function sources per vector, with vectors 2 and 26 reserved.
// RULE_20: DMA groups feed vectors 0-15 and 16-31; route line n feeds vector n.
// RULE_21: Source selection resets to fixed-function for every vector.
module nested_vector_controller #(
   parameter int NMI_PINS = 64
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [31:0] fixed_irq,
   input wire logic [15:0] dma_term_group_zero,
   input wire logic [15:0] dma_term_group_one,
   input wire logic [31:0] route_irq,
   input wire logic src_we,
   input wire logic [4:0] src_idx,
   input wire logic [1:0] src_val,
   input wire logic prio_we,
   input wire logic [5:0] prio_num,
   input wire logic [2:0] prio_val,
   input wire logic [1:0] grp_split,
   input wire logic [NMI_PINS-1:0] nmi_pin_in,
   input wire logic nmi_connect,
   input wire logic [$clog2(NMI_PINS)-1:0] nmi_pin_sel,
   input wire logic mem_fault,
   input wire logic bus_fault,
   input wire logic usage_fault,
   input wire logic [2:0] fault_en,
   input wire logic supervisor_call,
   input wire logic debug_mon_req,
   input wire logic deferred_service_request,
   input wire logic system_tick_exception,
   output logic fetch_req,
   output logic [9:0] fetch_addr,
   input wire logic fetch_ack,
   input wire logic [31:0] fetch_data,
   output logic [31:0] main_stack_pointer,
   output logic [31:0] reset_vector,
   output logic stack_push,
   output logic stack_pop,
   input wire logic stack_done,
   input wire logic exc_return,
   output logic exc_valid,
   output logic [5:0] exc_num,
   output logic [9:0] vec_offset,
   output logic tail_chain,
   output logic late_arrival
);
   generate
      if (NMI_PINS < 2 || NMI_PINS > 256) begin : g_bad_pins
         $error("NMI_PINS must lie between 2 and 256");
      end
   endgenerate

   localparam int N = nvc_pkg::NUM_EXC;

   function automatic logic [4:0] fkey(input logic [5:0] e,
                                       input logic [2:0] p);
      case (e)
         nvc_pkg::EXC_RESET: fkey = nvc_pkg::KEY_RESET;
         nvc_pkg::EXC_NMI: fkey = nvc_pkg::KEY_NMI;
         nvc_pkg::EXC_HARD: fkey = nvc_pkg::KEY_HARD;
         default: fkey = nvc_pkg::KEY_PROG + {2'h0, p};
      endcase
   endfunction : fkey

   // Group part only: subpriority bits shifted out
   function automatic logic [4:0] gkey(input logic [5:0] e,
                                       input logic [2:0] p,
                                       input logic [1:0] s);
      case (e)
         nvc_pkg::EXC_RESET: gkey = nvc_pkg::KEY_RESET;
         nvc_pkg::EXC_NMI: gkey = nvc_pkg::KEY_NMI;
         nvc_pkg::EXC_HARD: gkey = nvc_pkg::KEY_HARD;
         default: gkey = nvc_pkg::KEY_PROG + {2'h0, p >> s};
      endcase
   endfunction : gkey

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] irq_sel;

   irq_source_select #(.N(nvc_pkg::NUM_IRQ)) u_src (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .src_we(src_we),
      .src_idx(src_idx),
      .src_val(src_val),
      .fixed_irq(fixed_irq),
      .dma_term_group_zero(dma_term_group_zero),
      .dma_term_group_one(dma_term_group_one),
      .route_irq(route_irq),
      .irq_out(irq_sel)
   );

   ////////////////////////////////////////////////////////////////////////
   // NMI pin path: four flops, level accepted once stages two and three agree
   logic nmi_mux;
   logic nmi_s1_r, nmi_s2_r, nmi_s3_r, nmi_lvl_r;
   logic nmi_s1_nxt, nmi_s2_nxt, nmi_s3_nxt, nmi_lvl_nxt;
   logic nmi_edge;

   assign nmi_mux = nmi_connect & nmi_pin_in[nmi_pin_sel]; // RULE_10

   always_comb begin
      nmi_s1_nxt = nmi_mux;
      nmi_s2_nxt = nmi_s1_r;
      nmi_s3_nxt = nmi_s2_r;
      nmi_lvl_nxt = (nmi_s2_r == nmi_s3_r) ? nmi_s3_r : nmi_lvl_r;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         nmi_s1_r <= 1'b0;
         nmi_s2_r <= 1'b0;
         nmi_s3_r <= 1'b0;
         nmi_lvl_r <= 1'b0;
      end else if (ce) begin
         nmi_s1_r <= nmi_s1_nxt;
         nmi_s2_r <= nmi_s2_nxt;
         nmi_s3_r <= nmi_s3_nxt;
         nmi_lvl_r <= nmi_lvl_nxt;
      end
   end

   assign nmi_edge = nmi_lvl_nxt & ~nmi_lvl_r;

   ////////////////////////////////////////////////////////////////////////
   // Arbitration over pending and active sets
   logic [N-1:0] pend_r, pend_nxt, act_r, act_nxt;
   logic [2:0] prio_r [N];
   logic [2:0] prio_nxt [N];
   logic win_any;
   logic [5:0] win_num, top_num;
   logic [4:0] win_key, win_grp, top_key, cur_grp, cur_grp_ret, k;
   logic preempt, preempt_ret;

   always_comb begin
      win_any = 1'b0;
      win_num = 6'h00;
      win_key = nvc_pkg::KEY_THREAD;
      top_num = 6'h00;
      top_key = nvc_pkg::KEY_THREAD;
      cur_grp = nvc_pkg::KEY_THREAD;
      cur_grp_ret = nvc_pkg::KEY_THREAD;
      k = nvc_pkg::KEY_THREAD;
      // Descending walk with <= lets the lower number win a tie
      for (int i = N - 1; i >= 1; i--) begin
         k = fkey(6'(i), prio_r[i]);
         if (pend_r[i] && k <= win_key) begin // RULE_15
            win_any = 1'b1;
            win_num = 6'(i);
            win_key = k;
         end
         if (act_r[i] && k <= top_key) begin
            top_num = 6'(i);
            top_key = k;
         end
      end
      for (int i = 1; i < N; i++) begin
         k = gkey(6'(i), prio_r[i], grp_split);
         if (act_r[i] && k < cur_grp) begin
            cur_grp = k;
         end
         if (act_r[i] && 6'(i) != top_num && k < cur_grp_ret) begin
            cur_grp_ret = k;
         end
      end
      win_grp = gkey(win_num, prio_r[win_num], grp_split);
      preempt = win_any && (win_grp < cur_grp); // RULE_12
      preempt_ret = win_any && (win_grp < cur_grp_ret);
   end

   ////////////////////////////////////////////////////////////////////////
   // Entry/exit sequencing
   nvc_pkg::ctl_state_e state_r, state_nxt;
   logic [5:0] sel_num_r, sel_num_nxt, exc_num_nxt;
   logic [9:0] faddr_nxt, voff_nxt;
   logic [31:0] sp_nxt, rv_nxt;
   logic valid_nxt, tail_nxt, late_nxt, enter, retire;
   logic [5:0] enter_num;

   always_comb begin
      state_nxt = state_r;
      sel_num_nxt = sel_num_r;
      faddr_nxt = fetch_addr;
      sp_nxt = main_stack_pointer;
      rv_nxt = reset_vector;
      exc_num_nxt = exc_num;
      voff_nxt = vec_offset;
      valid_nxt = 1'b0;
      tail_nxt = 1'b0;
      late_nxt = 1'b0;
      enter = 1'b0;
      retire = 1'b0;
      enter_num = sel_num_r;
      case (state_r)
         nvc_pkg::ST_BOOT_SP: begin
            if (fetch_ack) begin
               sp_nxt = fetch_data; // RULE_02
               faddr_nxt = nvc_pkg::OFF_RESET;
               state_nxt = nvc_pkg::ST_BOOT_PC;
            end
         end
         nvc_pkg::ST_BOOT_PC: begin
            if (fetch_ack) begin
               rv_nxt = fetch_data; // RULE_02
               state_nxt = nvc_pkg::ST_RUN;
            end
         end
         nvc_pkg::ST_RUN: begin
            if (exc_return && (|act_r)) begin
               retire = 1'b1;
               if (preempt_ret) begin
                  enter = 1'b1; // RULE_13
                  enter_num = win_num;
                  tail_nxt = 1'b1;
               end else begin
                  state_nxt = nvc_pkg::ST_UNSTACK;
               end
            end else if (preempt) begin
               sel_num_nxt = win_num;
               state_nxt = nvc_pkg::ST_STACK;
            end
         end
         nvc_pkg::ST_STACK: begin
            if (stack_done) begin
               enter = 1'b1;
               state_nxt = nvc_pkg::ST_RUN;
            end else if (preempt && win_num != sel_num_r) begin
               sel_num_nxt = win_num; // RULE_13
               late_nxt = 1'b1;
            end
         end
         nvc_pkg::ST_UNSTACK: begin
            if (stack_done) begin
               state_nxt = nvc_pkg::ST_RUN;
            end
         end
         default: state_nxt = nvc_pkg::ST_BOOT_SP;
      endcase
      if (enter) begin
         valid_nxt = 1'b1;
         exc_num_nxt = enter_num; // RULE_01
         voff_nxt = {2'h0, enter_num, 2'h0}; // RULE_08
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_r <= nvc_pkg::ST_BOOT_SP;
         sel_num_r <= 6'h00;
         fetch_addr <= nvc_pkg::OFF_SP;
         main_stack_pointer <= 32'h0000_0000;
         reset_vector <= 32'h0000_0000;
         exc_num <= 6'h00;
         vec_offset <= 10'h000;
         exc_valid <= 1'b0;
         tail_chain <= 1'b0;
         late_arrival <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         sel_num_r <= sel_num_nxt;
         fetch_addr <= faddr_nxt;
         main_stack_pointer <= sp_nxt;
         reset_vector <= rv_nxt;
         exc_num <= exc_num_nxt;
         vec_offset <= voff_nxt;
         exc_valid <= valid_nxt;
         tail_chain <= tail_nxt;
         late_arrival <= late_nxt;
      end
   end

   assign fetch_req = (state_r == nvc_pkg::ST_BOOT_SP) ||
                      (state_r == nvc_pkg::ST_BOOT_PC);
   assign stack_push = (state_r == nvc_pkg::ST_STACK); // RULE_14
   assign stack_pop = (state_r == nvc_pkg::ST_UNSTACK); // RULE_14

   ////////////////////////////////////////////////////////////////////////
   // Priorities, pending and active bits
   logic [N-1:0] req;
   logic [2:0] fault_ok;
   logic [2:0] fault_in;

   assign fault_in = {usage_fault, bus_fault, mem_fault};

   always_comb begin
      req = '0;
      req[N-1:nvc_pkg::NUM_SYS] = irq_sel; // RULE_08
      req[nvc_pkg::EXC_NMI] = nmi_edge;
      req[nvc_pkg::EXC_CALL] = supervisor_call; // RULE_07
      req[nvc_pkg::EXC_DBG] = debug_mon_req;
      req[nvc_pkg::EXC_DEFER] = deferred_service_request;
      req[nvc_pkg::EXC_TICK] = system_tick_exception;
      for (int f = 0; f < 3; f++) begin
         fault_ok[f] = fault_en[f] && // RULE_04
            (gkey(nvc_pkg::EXC_MEM + 6'(f), // RULE_05
                  prio_r[nvc_pkg::EXC_MEM + 6'(f)], grp_split) < cur_grp);
         req[nvc_pkg::EXC_MEM + 6'(f)] = fault_in[f] & fault_ok[f]; // RULE_06
      end
      req[nvc_pkg::EXC_HARD] = |(fault_in & ~fault_ok); // RULE_03
   end

   always_comb begin
      prio_nxt = prio_r;
      if (prio_we && prio_num < 6'(N) && nvc_pkg::PROG_MASK[prio_num]) begin
         prio_nxt[prio_num] = prio_val; // RULE_11
      end
      act_nxt = act_r;
      pend_nxt = pend_r;
      if (retire) begin
         act_nxt[top_num] = 1'b0;
      end
      if (enter) begin
         act_nxt[enter_num] = 1'b1;
         pend_nxt[enter_num] = 1'b0;
      end
      // A new request in the entry cycle keeps its pending bit
      pend_nxt = pend_nxt | req;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pend_r <= '0;
         act_r <= '0;
         for (int i = 0; i < N; i++) begin
            prio_r[i] <= 3'h0;
         end
      end else if (ce) begin
         pend_r <= pend_nxt;
         act_r <= act_nxt;
         prio_r <= prio_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_boot_sp;
      @(posedge clk) disable iff (!rst_b)
         (state_r == nvc_pkg::ST_BOOT_SP) |-> fetch_addr == nvc_pkg::OFF_SP;
   endproperty
   a_boot_sp: assert property (p_boot_sp) // RULE_02
      else $error("stack pointer fetch not at offset zero");

   property p_vec_off;
      @(posedge clk) disable iff (!rst_b)
         exc_valid |-> (vec_offset == {2'h0, exc_num, 2'h0}) &&
                       (exc_num >= nvc_pkg::EXC_NMI);
   endproperty
   a_vec_off: assert property (p_vec_off) // RULE_08
      else $error("vector offset does not match exception number");

   property p_no_rsvd;
      @(posedge clk) disable iff (!rst_b)
         exc_valid |-> (exc_num < 6'h30) && !nvc_pkg::RSVD_MASK[exc_num];
   endproperty
   a_no_rsvd: assert property (p_no_rsvd) // RULE_07
      else $error("reserved exception number taken");

   property p_nmi_wins;
      @(posedge clk) disable iff (!rst_b)
         pend_r[nvc_pkg::EXC_NMI] |-> win_num == nvc_pkg::EXC_NMI;
   endproperty
   a_nmi_wins: assert property (p_nmi_wins) // RULE_03
      else $error("pending NMI lost arbitration");

   property p_escalate;
      @(posedge clk) disable iff (!rst_b)
         ce && (|(fault_in & ~fault_en)) |=> pend_r[nvc_pkg::EXC_HARD];
   endproperty
   a_escalate: assert property (p_escalate) // RULE_03
      else $error("disabled fault did not escalate");

   property p_mem;
      @(posedge clk) disable iff (!rst_b)
         ce && mem_fault && fault_ok[0] |=> pend_r[nvc_pkg::EXC_MEM];
   endproperty
   a_mem: assert property (p_mem) // RULE_04
      else $error("memory fault not pending");

   property p_bus;
      @(posedge clk) disable iff (!rst_b)
         ce && bus_fault && fault_ok[1] |=> pend_r[nvc_pkg::EXC_BUS];
   endproperty
   a_bus: assert property (p_bus) // RULE_05
      else $error("bus fault not pending");

   property p_usage;
      @(posedge clk) disable iff (!rst_b)
         ce && usage_fault && fault_ok[2] |=> pend_r[nvc_pkg::EXC_USAGE];
   endproperty
   a_usage: assert property (p_usage) // RULE_06
      else $error("usage fault not pending");

   property p_tail;
      @(posedge clk) disable iff (!rst_b)
         $rose(tail_chain) |-> exc_valid && $past(exc_return) && !stack_pop;
   endproperty
   a_tail: assert property (p_tail) // RULE_13
      else $error("tail chain without return or vector");

   property p_push;
      @(posedge clk) disable iff (!rst_b)
         $rose(exc_valid) && !tail_chain |-> $past(stack_push);
   endproperty
   a_push: assert property (p_push) // RULE_14
      else $error("vector issued without stacking");
endmodule : nested_vector_controller
`default_nettype wire

// >>> testbench/core_model.sv
// Processor core model: boot word fetch and stacking handshake
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] lat,
   input wire logic fetch_req,
   input wire logic [9:0] fetch_addr,
   output logic fetch_ack,
   output logic [31:0] fetch_data,
   input wire logic stack_push,
   input wire logic stack_pop,
   output logic stack_done
);
   localparam logic [31:0] SP_WORD = 32'h2000_7ff8;
   // Handler address with bit 0 set
   localparam logic [31:0] RV_WORD = 32'h0000_0a41;
   logic up;
   logic [3:0] cnt;
   initial begin
      fetch_ack = 1'b0;
      fetch_data = 32'h0;
      stack_done = 1'b0;
      cnt = 4'h0;
   end
   always @(posedge clk) begin
      up = rst_b;
      #1;
      fetch_ack = fetch_req & up;
      if (fetch_ack) begin
         fetch_data = (fetch_addr == 10'h000) ? SP_WORD : RV_WORD;
      end else begin
         // Idle bus shows junk, so a stale word cannot pass
         fetch_data = ~fetch_data;
      end
      // Slow or prompt stacking, set by lat
      if ((stack_push | stack_pop) & ~stack_done & up) begin
         stack_done = (cnt == lat);
         cnt = stack_done ? 4'h0 : cnt + 4'h1;
      end else begin
         stack_done = 1'b0;
      end
   end
endmodule : core_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the nested vector controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [31:0] fixed_irq = '0;
   logic [15:0] dma_term_group_zero = '0;
   logic [15:0] dma_term_group_one = '0;
   logic [31:0] route_irq = '0;
   logic src_we = 1'b0;
   logic [4:0] src_idx = '0;
   logic [1:0] src_val = '0;
   logic prio_we = 1'b0;
   logic [5:0] prio_num = '0;
   logic [2:0] prio_val = '0;
   logic [1:0] grp_split = '0;
   logic [63:0] nmi_pin_in = '0;
   logic nmi_connect = 1'b0;
   logic [5:0] nmi_pin_sel = '0;
   logic [2:0] flt = '0;
   logic [2:0] fault_en = '0;
   logic [3:0] sr = '0;
   logic [3:0] lat = 4'h0;
   logic exc_return = 1'b0;
   logic fetch_req, fetch_ack, stack_push, stack_pop, stack_done;
   logic exc_valid, tail_chain, late_arrival;
   int late_cnt = 0;
   logic [9:0] fetch_addr, vec_offset;
   logic [31:0] fetch_data, main_stack_pointer, reset_vector;
   logic [5:0] exc_num;
   int errors = 0;
   int checks = 0;
   always #20 clk = ~clk;
   nested_vector_controller u_nested_vector_controller (.clk, .rst_b,
      .ce(1'b1), .fixed_irq, .dma_term_group_zero, .dma_term_group_one,
      .route_irq, .src_we, .src_idx, .src_val, .prio_we, .prio_num,
      .prio_val, .grp_split, .nmi_pin_in, .nmi_connect, .nmi_pin_sel,
      .mem_fault(flt[0]), .bus_fault(flt[1]), .usage_fault(flt[2]),
      .fault_en, .supervisor_call(sr[0]), .debug_mon_req(sr[1]),
      .deferred_service_request(sr[2]), .system_tick_exception(sr[3]),
      .fetch_req, .fetch_addr, .fetch_ack, .fetch_data, .main_stack_pointer,
      .reset_vector, .stack_push, .stack_pop, .stack_done, .exc_return,
      .exc_valid, .exc_num, .vec_offset, .tail_chain, .late_arrival);
   core_model u_core_model (.clk, .rst_b, .lat, .fetch_req, .fetch_addr,
      .fetch_ack, .fetch_data, .stack_push, .stack_pop, .stack_done);
   always @(posedge clk) if (late_arrival === 1'b1) late_cnt <= late_cnt + 1;
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic final_report();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // Waits for an issued vector and checks number, offset and chaining
   task automatic enter(input logic [5:0] num, input logic tail);
      int i;
      i = 0;
      while (exc_valid !== 1'b1 && i < 200) begin
         step(1);
         i++;
      end
      cmp("exc_valid", 32'h1, {31'h0, exc_valid});
      cmp("exc_num", {26'h0, num}, {26'h0, exc_num});
      cmp("vec_offset", {24'h0, num, 2'h0}, {22'h0, vec_offset});
      cmp("tail_chain", {31'h0, tail}, {31'h0, tail_chain});
   endtask : enter
   task automatic leave();
      int i;
      i = 0;
      exc_return = 1'b1;
      step(1);
      exc_return = 1'b0;
      while (stack_pop === 1'b1 && i < 50) begin
         step(1);
         i++;
      end
      cmp("stack_pop", 32'h0, {31'h0, stack_pop});
   endtask : leave
   task automatic quiet(input int n);
      int hits;
      hits = 0;
      repeat (n) begin
         step(1);
         if (exc_valid !== 1'b0) hits++;
      end
      cmp("no issue", 32'h0, hits);
   endtask : quiet
   task automatic irq(input int v);
      fixed_irq[v] = 1'b1;
      step(1);
      fixed_irq = '0;
   endtask : irq
   task automatic setp(input logic [5:0] n, input logic [2:0] v);
      prio_we = 1'b1;
      prio_num = n;
      prio_val = v;
      step(1);
      prio_we = 1'b0;
      step(1);
   endtask : setp
   task automatic setsrc(input logic [4:0] n, input logic [1:0] v);
      src_we = 1'b1;
      src_idx = n;
      src_val = v;
      step(1);
      src_we = 1'b0;
      step(1);
   endtask : setsrc
   ////////////////////////////////////////////////////////////////////////
   task automatic s_boot();
      cmp("fetch_addr", 32'h0, {22'h0, fetch_addr});
      rst_b = 1'b1;
      step(4);
      cmp("fetch_req", 32'h0, {31'h0, fetch_req});
      cmp("stack pointer", 32'h2000_7ff8, main_stack_pointer);
      cmp("reset vector", 32'h0000_0a41, reset_vector);
   endtask : s_boot
   task automatic s_sources();
      irq(5);
      enter(6'h15, 1'b0);
      leave();
      irq(2);
      quiet(20);
      setsrc(5'd20, 2'h1);
      dma_term_group_one[4] = 1'b1;
      step(1);
      dma_term_group_one = '0;
      enter(6'h24, 1'b0);
      leave();
      setsrc(5'd3, 2'h1);
      dma_term_group_zero[3] = 1'b1;
      step(1);
      dma_term_group_zero = '0;
      enter(6'h13, 1'b0);
      leave();
      setsrc(5'd3, 2'h3);
      irq(3);
      quiet(10);
      setsrc(5'd7, 2'h2);
      irq(7);
      quiet(20);
      route_irq[7] = 1'b1;
      step(1);
      route_irq = '0;
      enter(6'h17, 1'b0);
      leave();
   endtask : s_sources
   task automatic s_order();
      fixed_irq = 32'h0000_0220;
      step(1);
      fixed_irq = '0;
      enter(6'h15, 1'b0);
      exc_return = 1'b1;
      step(1);
      exc_return = 1'b0;
      enter(6'h19, 1'b1);
      leave();
      setp(6'h15, 3'h5);
      setp(6'h19, 3'h2);
      setp(6'h1a, 3'h0);
      fixed_irq = 32'h0000_0220;
      step(1);
      fixed_irq = '0;
      enter(6'h19, 1'b0);
      step(2);
      irq(10);
      enter(6'h1a, 1'b0);
      leave();
      exc_return = 1'b1;
      step(1);
      exc_return = 1'b0;
      enter(6'h15, 1'b1);
      grp_split = 2'h3;
      step(2);
      irq(10);
      quiet(30);
      exc_return = 1'b1;
      step(1);
      exc_return = 1'b0;
      enter(6'h1a, 1'b1);
      leave();
      grp_split = 2'h0;
   endtask : s_order
   task automatic s_late();
      int l0;
      l0 = late_cnt;
      lat = 4'h8;
      setp(6'h1c, 3'h6);
      irq(12);
      step(2);
      irq(11);
      enter(6'h1b, 1'b0);
      cmp("late_arrival", 32'h1, late_cnt - l0);
      exc_return = 1'b1;
      step(1);
      exc_return = 1'b0;
      enter(6'h1c, 1'b1);
      leave();
      lat = 4'h0;
   endtask : s_late
   task automatic s_system();
      logic [5:0] nums [4] = '{6'h0b, 6'h0c, 6'h0e, 6'h0f};
      fault_en = 3'h7;
      for (int k = 0; k < 3; k++) begin
         flt[k] = 1'b1;
         step(1);
         flt = '0;
         enter(6'h04 + 6'(k), 1'b0);
         leave();
      end
      fault_en = 3'h0;
      flt[2] = 1'b1;
      step(1);
      flt = '0;
      enter(6'h03, 1'b0);
      leave();
      for (int k = 0; k < 4; k++) begin
         sr[k] = 1'b1;
         step(1);
         sr = '0;
         enter(nums[k], 1'b0);
         leave();
      end
      nmi_connect = 1'b1;
      nmi_pin_sel = 6'd37;
      nmi_pin_in[37] = 1'b1;
      enter(6'h02, 1'b0);
      leave();
      nmi_pin_in = '0;
      nmi_connect = 1'b0;
      step(6);
      nmi_pin_in[37] = 1'b1;
      quiet(20);
   endtask : s_system
   ////////////////////////////////////////////////////////////////////////
   initial begin
      step(3);
      s_boot();
      s_sources();
      s_order();
      s_late();
      s_system();
      final_report();
   end
   // Whole run needs a few hundred cycles; the limit allows 10000
   initial begin
      #400000;
      errors++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
